// File: hdl/acd_pkg.sv
// Behaviour
// R1 - system clock runs at 500kHz and is also the converter sampling clock
// R2 - external clock passes a divide-by-two chain; divide field picks stage count
// R3 - acquisition times scale linearly with derived clock relative to 500kHz
// R4 - bus field sets bus conversion time, shunt field sets shunt conversion time
// R5 - conversion setting 3 takes 508us at nominal clock, longer when slower
// R6 - clock source and divide keep derived clock at or below 500kHz; the bench runs the external clock at /1, giving 3.9MHz
// R7 - external clock pin frequency stays at or below 4MHz
`default_nettype none
package acd_pkg;
	localparam int unsigned CLK_FREQ_HZ  = 250_000_000;
	localparam int unsigned SYS_FREQ_HZ  = 500_000;
	localparam int unsigned OSC_DIV_CYC  = CLK_FREQ_HZ / SYS_FREQ_HZ;
	localparam int unsigned OSC_CNT_W    = 9;
	localparam int unsigned DIV_STAGES   = 3;
	localparam int unsigned DIV_SEL_W    = 2;
	localparam int unsigned CONV_W       = 4;
	localparam int unsigned TICK_W       = 20;
	localparam int unsigned REF_SETTING  = 3;
	localparam int unsigned ACQ_REF_US   = 508;
	localparam int unsigned ACQ_REF_TICKS = ACQ_REF_US * (SYS_FREQ_HZ / 1_000) / 1_000;

	typedef enum logic [1:0] {
		ACD_IDLE,
		ACD_BUS,
		ACD_SHUNT
	} acd_state_t;

	typedef struct packed {
		logic [CONV_W-1:0] busConversionField;
		logic [CONV_W-1:0] shuntConversionField;
	} acd_conv_cfg_t;

	typedef struct packed {
		logic busy;
		logic phaseShunt;
		logic busDone;
		logic shuntDone;
	} acd_status_t;
endpackage
`default_nettype wire

// File: hdl/acd_clock_divider.sv
`timescale 1ns/10ps
`default_nettype none
module acd_clock_divider (
	input  wire logic                            clk,
	input  wire logic                            nrst,
	input  wire logic                            ce,
	input  wire logic                            extClockSel,
	input  wire logic [acd_pkg::DIV_SEL_W-1:0]   clockDivideField,
	input  wire logic                            externalClockInput,
	input  wire acd_pkg::acd_conv_cfg_t          convCfg,
	input  wire logic                            convStart,
	output logic                                 sysTick,
	output acd_pkg::acd_status_t                 status
);
	logic [acd_pkg::OSC_CNT_W-1:0]  oscCnt_r;
	logic                           extIn_r;
	logic [acd_pkg::DIV_STAGES-1:0] stage_r;
	logic [acd_pkg::DIV_STAGES:0]   stageRise;
	logic                           tickNxt;
	logic                           sysTick_r;
	acd_pkg::acd_state_t            state_r;
	logic [acd_pkg::TICK_W-1:0]     tickCnt_r;
	logic [acd_pkg::TICK_W-1:0]     target_r;
	logic                           busDone_r;
	logic                           shuntDone_r;
	logic                           phaseEnd;

	localparam logic [acd_pkg::OSC_CNT_W-1:0] OSC_LAST = acd_pkg::OSC_CNT_W'(acd_pkg::OSC_DIV_CYC - 1);
	localparam logic [acd_pkg::TICK_W-1:0]    REF_TICKS = acd_pkg::TICK_W'(acd_pkg::ACQ_REF_TICKS);

	// ticks for a setting: reference doubles per step above 3, halves below
	function automatic logic [acd_pkg::TICK_W-1:0] convTicks(input logic [acd_pkg::CONV_W-1:0] s);
		logic [acd_pkg::TICK_W-1:0] t;
		t = REF_TICKS;
		if (s >= acd_pkg::CONV_W'(acd_pkg::REF_SETTING)) begin
			t = REF_TICKS << (s - acd_pkg::CONV_W'(acd_pkg::REF_SETTING));
		end else begin
			t = REF_TICKS >> (acd_pkg::CONV_W'(acd_pkg::REF_SETTING) - s);
		end
		return t;
	endfunction

	// internal oscillator: one tick every 500 fast cycles gives 500kHz
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			oscCnt_r <= '0;
		end else if (ce) begin
			if (oscCnt_r == OSC_LAST) begin // see R1
				oscCnt_r <= '0;
			end else begin
				oscCnt_r <= oscCnt_r + acd_pkg::OSC_CNT_W'(1);
			end
		end
	end

	// pin is synchronous; hysteresis of the input buffer is left to the pad
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			extIn_r <= 1'b0;
		end else if (ce) begin
			extIn_r <= externalClockInput;
		end
	end

	// each stage toggles on the rising edge of the one before it
	always_comb begin
		stageRise[0] = externalClockInput & ~extIn_r;
		for (int k = 0; k < acd_pkg::DIV_STAGES; k++) begin
			stageRise[k+1] = stageRise[k] & ~stage_r[k]; // see R2
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage_r <= '0;
		end else if (ce) begin
			for (int k = 0; k < acd_pkg::DIV_STAGES; k++) begin
				if (stageRise[k]) begin
					stage_r[k] <= ~stage_r[k]; // see R2
				end
			end
		end
	end

	assign tickNxt = extClockSel ? stageRise[clockDivideField] : (oscCnt_r == OSC_LAST); // see R1 R2

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sysTick_r <= 1'b0;
		end else if (ce) begin
			sysTick_r <= tickNxt;
		end
	end

	assign sysTick = sysTick_r & ce;

	// conversion lengths count system ticks, so a slower clock stretches them
	assign phaseEnd = sysTick && (tickCnt_r == target_r - acd_pkg::TICK_W'(1)); // see R3 R5

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= acd_pkg::ACD_IDLE;
			tickCnt_r <= '0;
			target_r  <= '0;
		end else if (ce) begin
			unique case (state_r)
				acd_pkg::ACD_IDLE: begin
					tickCnt_r <= '0;
					if (convStart) begin
						target_r <= convTicks(convCfg.busConversionField); // see R4
						state_r  <= acd_pkg::ACD_BUS;
					end
				end
				acd_pkg::ACD_BUS: begin
					if (phaseEnd) begin
						tickCnt_r <= '0;
						target_r  <= convTicks(convCfg.shuntConversionField); // see R4
						state_r   <= acd_pkg::ACD_SHUNT;
					end else if (sysTick) begin
						tickCnt_r <= tickCnt_r + acd_pkg::TICK_W'(1);
					end
				end
				acd_pkg::ACD_SHUNT: begin
					if (phaseEnd) begin
						tickCnt_r <= '0;
						state_r   <= acd_pkg::ACD_IDLE;
					end else if (sysTick) begin
						tickCnt_r <= tickCnt_r + acd_pkg::TICK_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busDone_r   <= 1'b0;
			shuntDone_r <= 1'b0;
		end else if (ce) begin
			busDone_r   <= phaseEnd && (state_r == acd_pkg::ACD_BUS);
			shuntDone_r <= phaseEnd && (state_r == acd_pkg::ACD_SHUNT);
		end else begin
			busDone_r   <= 1'b0;
			shuntDone_r <= 1'b0;
		end
	end

	always_comb begin
		status.busy       = (state_r != acd_pkg::ACD_IDLE);
		status.phaseShunt = (state_r == acd_pkg::ACD_SHUNT);
		status.busDone    = busDone_r;
		status.shuntDone  = shuntDone_r;
	end

	// helper: ticks seen in the current phase; it restarts on a change of state,
	// not on phaseEnd, so the length checks do not lean on the counter they judge
	acd_pkg::acd_state_t            phasePrev_r;
	logic [acd_pkg::TICK_W-1:0]     phaseTicks_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phasePrev_r  <= acd_pkg::ACD_IDLE;
			phaseTicks_r <= '0;
		end else if (ce) begin
			phasePrev_r <= state_r;
			if (state_r == acd_pkg::ACD_IDLE) begin
				phaseTicks_r <= '0;
			end else if (state_r != phasePrev_r) begin
				phaseTicks_r <= acd_pkg::TICK_W'(sysTick);
			end else if (sysTick) begin
				phaseTicks_r <= phaseTicks_r + acd_pkg::TICK_W'(1);
			end
		end
	end

	osc_period_a: assert property (@(posedge clk) disable iff (!nrst) // see R1
		(ce && !extClockSel && oscCnt_r == OSC_LAST) |=> (oscCnt_r == '0) && (sysTick_r == 1'b1))
		else $error("internal tick not produced at end of oscillator period");

	osc_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // see R1
		(ce && !extClockSel && oscCnt_r != OSC_LAST) |=> !sysTick_r)
		else $error("internal tick outside oscillator period end");

	div_select_a: assert property (@(posedge clk) disable iff (!nrst) // see R2
		(ce && extClockSel && externalClockInput && !extIn_r && stage_r[0] && clockDivideField != '0)
		|=> !sysTick_r)
		else $error("divided tick fired on an odd input edge");

	div_bypass_a: assert property (@(posedge clk) disable iff (!nrst) // see R2
		(ce && extClockSel && clockDivideField == '0 && externalClockInput && !extIn_r) |=> sysTick_r)
		else $error("undivided external edge did not tick");

	phase_len_a: assert property (@(posedge clk) disable iff (!nrst) // see R3 R5
		(ce && phaseEnd) |-> (phaseTicks_r + acd_pkg::TICK_W'(1) == target_r))
		else $error("phase ended at wrong tick count");

	phase_cap_a: assert property (@(posedge clk) disable iff (!nrst) // see R3 R5
		(ce && status.busy && state_r == phasePrev_r) |-> (phaseTicks_r < target_r))
		else $error("phase ran past its tick count");

	phase_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see R4
		(ce && status.busy && !phaseEnd) |=> $stable(state_r) && $stable(target_r))
		else $error("phase or length changed before the phase ended");

	freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst) // see R1 R2
		!ce |=> $stable(oscCnt_r) && $stable(stage_r) && $stable(sysTick_r) && $stable(tickCnt_r))
		else $error("state moved while clock enable was low");

	bus_target_a: assert property (@(posedge clk) disable iff (!nrst) // see R4
		(ce && state_r == acd_pkg::ACD_IDLE && convStart)
		|=> (target_r == $past(convTicks(convCfg.busConversionField))) && status.busy)
		else $error("bus phase loaded wrong length");

	shunt_target_a: assert property (@(posedge clk) disable iff (!nrst) // see R4
		(ce && state_r == acd_pkg::ACD_BUS && phaseEnd)
		|=> status.phaseShunt && busDone_r && (target_r == $past(convTicks(convCfg.shuntConversionField))))
		else $error("shunt phase loaded wrong length");

	ref_setting_a: assert property (@(posedge clk) disable iff (!nrst) // see R5
		(ce && state_r == acd_pkg::ACD_IDLE && convStart
			&& convCfg.busConversionField == acd_pkg::CONV_W'(acd_pkg::REF_SETTING))
		|=> (target_r == REF_TICKS))
		else $error("setting 3 is not 254 system ticks");
endmodule // acd_clock_divider
`default_nettype wire

// File: verif/acd_ext_clk_src.sv
`timescale 1ns/10ps
`default_nettype none
module acd_ext_clk_src (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [7:0] halfPeriod,
	output logic            extClk
);
	logic [7:0] cnt_r;

	// halfPeriod of 32 or more keeps the pin at or below 4MHz
	// derived rate is this pin rate over the divide field the bench picks; at /1 it stays at 3.9MHz
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r  <= 8'h00;
			extClk <= 1'b0;
		end else if (cnt_r >= halfPeriod - 8'h01) begin
			cnt_r  <= 8'h00;
			extClk <= ~extClk;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule // acd_ext_clk_src
`default_nettype wire

// File: verif/acd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                          clk;
	logic                          nrst;
	logic                          ce;
	logic                          extClockSel;
	logic [acd_pkg::DIV_SEL_W-1:0] clockDivideField;
	logic                          externalClockInput;
	acd_pkg::acd_conv_cfg_t        convCfg;
	logic                          convStart;
	logic                          sysTick;
	acd_pkg::acd_status_t          status;
	int                            errors;
	int                            compares;

	// 32-cycle halves give 3.9MHz on the pin, under its 4MHz limit
	localparam logic [7:0] EXT_HALF   = 8'h20;
	localparam int         EXT_PERIOD = 2 * EXT_HALF;

	acd_ext_clk_src SRC (.clk(clk), .nrst(nrst), .halfPeriod(EXT_HALF), .extClk(externalClockInput));
	acd_clock_divider DUT (.clk(clk), .nrst(nrst), .ce(ce), .extClockSel(extClockSel),
		.clockDivideField(clockDivideField), .externalClockInput(externalClockInput),
		.convCfg(convCfg), .convStart(convStart), .sysTick(sysTick), .status(status));

	task automatic finish_test();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s seen %0d exp %0d", $time, msg, seen, exp);
		end
	endtask

	// counts cycles until a tick, or until the chosen done pulse while counting ticks
	task automatic wait_ev(input int mode, output int n, output int k);
		n = 0;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (sysTick === 1'b1)
				k++;
		end while ((mode == 0 ? sysTick : mode == 1 ? status.busDone : status.shuntDone) !== 1'b1 && n < 40000);
		if (n >= 40000) begin
			errors++;
			finish_test();
		end
	endtask

	task automatic t_internal();
		int n;
		int k;
		extClockSel <= 1'b0;
		wait_ev(0, n, k);
		wait_ev(0, n, k);
		wait_ev(0, n, k);
		check(n, acd_pkg::CLK_FREQ_HZ / acd_pkg::SYS_FREQ_HZ, "int period");
		@(posedge clk) ce <= 1'b0;
		repeat (600) begin
			@(posedge clk);
			#1;
			check(sysTick, 1'b0, "tick while frozen");
		end
		@(posedge clk) ce <= 1'b1;
		// one oscillator count was used before the freeze, so the rest is one short
		wait_ev(0, n, k);
		check(n, acd_pkg::CLK_FREQ_HZ / acd_pkg::SYS_FREQ_HZ - 1, "resume after freeze");
	endtask

	task automatic t_divide();
		int n;
		int k;
		@(posedge clk) extClockSel <= 1'b1;
		for (int d = 0; d < 4; d++) begin
			@(posedge clk) clockDivideField <= d[acd_pkg::DIV_SEL_W-1:0];
			repeat (3) wait_ev(0, n, k);
			check(n, EXT_PERIOD << d, "ext period");
		end
	endtask

	// over-speed /1 setting trades converter accuracy for run length
	task automatic t_conv(input logic [3:0] b, input logic [3:0] s);
		int n;
		int nb;
		int kb;
		int ks;
		int ref_t;
		int eb;
		int es;
		ref_t = acd_pkg::ACQ_REF_US * (acd_pkg::SYS_FREQ_HZ / 1000) / 1000;
		eb = (b == 4'h3) ? ref_t : 31;
		es = (s == 4'h3) ? ref_t : 31;
		@(posedge clk) clockDivideField <= 2'h0;
		wait_ev(0, n, kb);
		@(posedge clk) convCfg <= '{busConversionField: b, shuntConversionField: s};
		convStart <= 1'b1;
		@(posedge clk) convStart <= 1'b0;
		wait_ev(1, nb, kb);
		check(status.phaseShunt, 1'b1, "shunt phase");
		wait_ev(2, n, ks);
		check(status.busy, 1'b0, "busy after shunt");
		check(kb, eb, "bus ticks");
		check(ks, es, "shunt ticks");
		// bus count starts two cycles after the sync tick, hence one cycle short
		check(nb, EXT_PERIOD * eb - 1, "bus cycles");
		check(n, EXT_PERIOD * es, "shunt cycles");
	endtask

	// reset in mid-conversion: everything clears and the oscillator starts over
	task automatic t_reset();
		int n;
		int k;
		@(posedge clk) extClockSel <= 1'b0;
		convStart <= 1'b1;
		@(posedge clk) convStart <= 1'b0;
		@(posedge clk) #1;
		check(status.busy, 1'b1, "busy before reset");
		@(posedge clk) nrst <= 1'b0;
		@(posedge clk) #1;
		check(status, 4'h0, "status in reset");
		check(sysTick, 1'b0, "tick in reset");
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		wait_ev(0, n, k);
		check(n, acd_pkg::CLK_FREQ_HZ / acd_pkg::SYS_FREQ_HZ, "first tick after reset");
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		errors = 0;
		compares = 0;
		nrst = 1'b0;
		ce = 1'b1;
		extClockSel = 1'b0;
		clockDivideField = 2'h0;
		convCfg = '0;
		convStart = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_internal();
		t_divide();
		t_conv(4'h3, 4'h0);
		t_conv(4'h0, 4'h3);
		t_reset();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
